//--- src/flash_ctrl_defines.vh
/*
 Timing figures and command-port encodings for the parallel flash host controller.
 Assumes inclusion by bare name from the design files under src/.
*/
`ifndef FLASH_CTRL_DEFINES_VH
`define FLASH_CTRL_DEFINES_VH

// ------------------------------------------------------------
// Clock
// ------------------------------------------------------------
`define CLK_PERIOD_NS        10

// ------------------------------------------------------------
// Device timing, ns as printed or chosen
// ------------------------------------------------------------
`define SELECT_ACCESS_TIME_NS   120
`define RESET_PULSE_WIDTH_NS    500
`define RESET_RECOVERY_TIME_NS  50
`define WRITE_PULSE_NS          50
`define WRITE_HIGH_NS           30

// ------------------------------------------------------------
// Cycle counts at the clock period above (least times round up)
// ------------------------------------------------------------
// Read window: select time, one cycle of margin, two for the data synchroniser
`define SELECT_ACCESS_CYC  8'h0F
`define RESET_PULSE_CYC    8'h32
`define RESET_RECOV_CYC    8'h05
`define WRITE_PULSE_CYC    8'h05
`define WRITE_HIGH_CYC     8'h03

// ------------------------------------------------------------
// Command port operation codes
// ------------------------------------------------------------
`define OP_READ    2'h0
`define OP_WRITE   2'h1
`define OP_RESET   2'h2

// ------------------------------------------------------------
// Widths
// ------------------------------------------------------------
`define ADDR_W   19
`define DATA_W   16
`define CNT_W    8

`endif

//--- src/flash_wait_timer.v
/*
 Down-counter giving a done pulse after a loaded number of cycles.
 Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "flash_ctrl_defines.vh"

module flash_wait_timer
(
	input  wire                 clk,
	input  wire                 resetn,
	input  wire                 load,
	input  wire [`CNT_W-1:0]    count,
	output wire                 done
);

	reg [`CNT_W-1:0] cnt_ff;
	reg              run_ff;

	assign done = run_ff && (cnt_ff == 8'h01);

	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt_ff <= 8'h00;
			run_ff <= 1'b0;
		end
		else if (load)
		begin
			cnt_ff <= count;
			run_ff <= 1'b1;
		end
		else if (run_ff)
		begin
			cnt_ff <= cnt_ff - 8'h01;
			if (cnt_ff == 8'h01)
				run_ff <= 1'b0;
		end
	end

endmodule
`default_nettype wire

//--- src/flash_host_ctrl.v
/*
 Host-side controller that drives a parallel NOR flash through its pins:
 timed read, write-cycle and hardware-reset sequences from a simple command port.
 Assumes the flash pins are wired directly, inputs asynchronous to CLK.
*/
// Behaviour
// - Read with select, gate low, strobe high
// - Write with strobe, select low, gate high
// - Bypass programming uses two writes, not four
// - Reads from standby wait select access time
// - Host reissues operation interrupted by reset; this controller leaves that to the caller
// - Host waits recovery time before reading
`timescale 1ns/1ps
`default_nettype none
`include "flash_ctrl_defines.vh"

module flash_host_ctrl
(
	input  wire                 CLK,
	input  wire                 RESETN,
	input  wire                 REQ_VALID,
	output wire                 REQ_READY,
	input  wire [1:0]           REQ_OP,
	input  wire [`ADDR_W-1:0]   REQ_ADDR,
	input  wire [`DATA_W-1:0]   REQ_WDATA,
	input  wire                 BYTE_MODE,
	output reg                  RSP_VALID,
	output reg  [`DATA_W-1:0]   RSP_RDATA,
	output reg                  BUSY,
	output reg  [17:0]          FL_ADDR,
	output reg                  FL_CE_N,
	output reg                  FL_OE_N,
	output reg                  FL_WE_N,
	output reg                  FL_RESET_N,
	output reg                  FL_BYTE_N,
	input  wire [`DATA_W-1:0]   FL_DQ_I,
	output reg  [`DATA_W-1:0]   FL_DQ_O,
	output reg  [`DATA_W-1:0]   FL_DQ_OE,
	input  wire                 FL_READY_BUSY_N
);

	// ------------------------------------------------------------
	// States
	// ------------------------------------------------------------
	localparam ST_IDLE   = 3'h0;
	localparam ST_READ   = 3'h1;
	localparam ST_WLOW   = 3'h2;
	localparam ST_WHIGH  = 3'h3;
	localparam ST_RPULSE = 3'h4;
	localparam ST_RRECOV = 3'h5;

	reg [2:0]         state_ff;
	reg [2:0]         nxt_state;
	reg [`DATA_W-1:0] dq_s1_ff;
	reg [`DATA_W-1:0] dq_s2_ff;
	reg               rb_s1_ff;
	reg               rb_s2_ff;
	reg               byte_ff;
	reg               tmr_load;
	reg [`CNT_W-1:0]  tmr_count;
	wire              tmr_done;

	assign REQ_READY = (state_ff == ST_IDLE);

	// ------------------------------------------------------------
	// Synchronisers
	// ------------------------------------------------------------
	always @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			dq_s1_ff <= 16'h0000;
			dq_s2_ff <= 16'h0000;
			rb_s1_ff <= 1'b1;
			rb_s2_ff <= 1'b1;
		end
		else
		begin
			dq_s1_ff <= FL_DQ_I;
			dq_s2_ff <= dq_s1_ff;
			rb_s1_ff <= FL_READY_BUSY_N;
			rb_s2_ff <= rb_s1_ff;
		end
	end

	flash_wait_timer u_timer
	(
		.clk    (CLK),
		.resetn (RESETN),
		.load   (tmr_load),
		.count  (tmr_count),
		.done   (tmr_done)
	);

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always @*
	begin
		nxt_state = state_ff;
		tmr_load  = 1'b0;
		tmr_count = 8'h00;
		case (state_ff)
			ST_IDLE:
			begin
				if (REQ_VALID)
				begin
					tmr_load = 1'b1;
					case (REQ_OP)
						`OP_READ:
						begin
							// Full select time covers a read leaving standby
							nxt_state = ST_READ;
							tmr_count = `SELECT_ACCESS_CYC;
						end
						`OP_WRITE:
						begin
							// One bus write; unlock, bypass, erase sequences are caller-built
							nxt_state = ST_WLOW;
							tmr_count = `WRITE_PULSE_CYC;
						end
						`OP_RESET:
						begin
							nxt_state = ST_RPULSE;
							tmr_count = `RESET_PULSE_CYC;
						end
						default:
						begin
							tmr_load = 1'b0;
						end
					endcase
				end
			end
			ST_READ:
				if (tmr_done)
					nxt_state = ST_IDLE;
			ST_WLOW:
			begin
				if (tmr_done)
				begin
					nxt_state = ST_WHIGH;
					tmr_load  = 1'b1;
					tmr_count = `WRITE_HIGH_CYC;
				end
			end
			ST_WHIGH:
				if (tmr_done)
					nxt_state = ST_IDLE;
			ST_RPULSE:
			begin
				if (tmr_done)
				begin
					nxt_state = ST_RRECOV;
					tmr_load  = 1'b1;
					tmr_count = `RESET_RECOV_CYC;
				end
			end
			ST_RRECOV:
				if (tmr_done)
					nxt_state = ST_IDLE;
			default:
				nxt_state = ST_IDLE;
		endcase
	end

	// ------------------------------------------------------------
	// Pin drive
	// ------------------------------------------------------------
	always @(posedge CLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			state_ff   <= ST_IDLE;
			FL_ADDR    <= 18'h00000;
			FL_CE_N    <= 1'b1;
			FL_OE_N    <= 1'b1;
			FL_WE_N    <= 1'b1;
			FL_RESET_N <= 1'b1;
			FL_BYTE_N  <= 1'b1;
			FL_DQ_O    <= 16'h0000;
			FL_DQ_OE   <= 16'h0000;
			byte_ff    <= 1'b0;
			RSP_VALID  <= 1'b0;
			RSP_RDATA  <= 16'h0000;
			BUSY       <= 1'b0;
		end
		else
		begin
			state_ff  <= nxt_state;
			RSP_VALID <= 1'b0;
			BUSY      <= !rb_s2_ff;
			if (state_ff == ST_IDLE && REQ_VALID)
			begin
				byte_ff   <= BYTE_MODE;
				FL_BYTE_N <= !BYTE_MODE;
				FL_ADDR   <= BYTE_MODE ? REQ_ADDR[18:1] : REQ_ADDR[17:0];
				FL_DQ_O   <= BYTE_MODE ? {REQ_ADDR[0], 7'h00, REQ_WDATA[7:0]} : REQ_WDATA;
				// Byte mode: top line carries the least address bit always
				FL_DQ_OE  <= BYTE_MODE ? 16'h8000 : 16'h0000;
				case (REQ_OP)
					`OP_READ:
					begin
						FL_CE_N <= 1'b0;
						FL_OE_N <= 1'b0;
						FL_WE_N <= 1'b1;
					end
					`OP_WRITE:
					begin
						FL_CE_N  <= 1'b0;
						FL_OE_N  <= 1'b1;
						FL_WE_N  <= 1'b0;
						FL_DQ_OE <= BYTE_MODE ? 16'h80FF : 16'hFFFF;
					end
					`OP_RESET:
						FL_RESET_N <= 1'b0;
					default:
						FL_CE_N <= 1'b1;
				endcase
			end
			else if (state_ff == ST_READ && tmr_done)
			begin
				// Status and identification codes only use the low byte
				RSP_RDATA <= byte_ff ? {8'h00, dq_s2_ff[7:0]} : dq_s2_ff;
				RSP_VALID <= 1'b1;
				FL_CE_N   <= 1'b1;
				FL_OE_N   <= 1'b1;
			end
			else if (state_ff == ST_WLOW && tmr_done)
			begin
				FL_WE_N <= 1'b1;
				FL_CE_N <= 1'b1;
			end
			else if (state_ff == ST_WHIGH && tmr_done)
				FL_DQ_OE <= byte_ff ? 16'h8000 : 16'h0000;
			else if (state_ff == ST_RPULSE && tmr_done)
				FL_RESET_N <= 1'b1;
		end
	end

endmodule
`default_nettype wire

//--- dv/flash_host_chk.sv
/* Assertions on the pins of the flash host controller.
 Bound to flash_host_ctrl, sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module flash_host_chk
(
	input wire logic        CLK,
	input wire logic        RESETN,
	input wire logic        REQ_VALID,
	input wire logic        REQ_READY,
	input wire logic [1:0]  REQ_OP,
	input wire logic        RSP_VALID,
	input wire logic        BUSY,
	input wire logic        FL_CE_N,
	input wire logic        FL_OE_N,
	input wire logic        FL_WE_N,
	input wire logic        FL_RESET_N,
	input wire logic        FL_BYTE_N,
	input wire logic [15:0] FL_DQ_OE,
	input wire logic        FL_READY_BUSY_N
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);
	// ------------------------------------------------------------
	// Pin relations
	// ------------------------------------------------------------
	chk_read_levels: assert property (!FL_OE_N |-> !FL_CE_N && FL_WE_N)
		else $error("gate low outside a read");
	chk_write_levels: assert property (!FL_WE_N |-> !FL_CE_N && FL_OE_N && FL_DQ_OE[7:0] == 8'hFF)
		else $error("bad write cycle levels");
	chk_write_pulse: assert property ($fell(FL_WE_N) |-> !FL_WE_N [*5] ##1 FL_WE_N)
		else $error("write strobe width wrong");
	chk_byte_float: assert property (!FL_BYTE_N |-> FL_DQ_OE[14:8] == 7'h00)
		else $error("upper lines driven in byte mode");
	chk_read_answer: assert property (REQ_VALID && REQ_READY && REQ_OP == 2'h0 |-> ##16 RSP_VALID)
		else $error("read answer late");
	chk_select_hold: assert property ($fell(FL_OE_N) |-> !FL_OE_N [*8] ##1 !FL_OE_N [*7])
		else $error("read window too short");
	chk_pulse_width: assert property ($fell(FL_RESET_N) |-> !FL_RESET_N [*8])
		else $error("reset pulse too short");
	chk_recovery: assert property ($rose(FL_RESET_N) |-> FL_CE_N [*5])
		else $error("access before recovery");
	chk_busy_sync: assert property (!FL_READY_BUSY_N [*4] |-> BUSY)
		else $error("busy not reported");
endmodule
bind flash_host_ctrl flash_host_chk chk (.*);
`default_nettype wire

//--- dv/flash_dev_model.sv
/* Behavioural flash device for the host controller bench.
 Assumes one bench clock to time access and embedded operations. */
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(parameter [7:0] ID_CODE = 8'h5A) // Arbitrary code
(
	input  wire logic        clk,
	input  wire logic [17:0] addr,
	input  wire logic        ce_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic        reset_n,
	input  wire logic        byte_n,
	input  wire logic [15:0] dq_in,
	output wire logic [15:0] dq_out,
	output wire logic        ready_busy_n
);
	logic [15:0] mem [0:7];
	logic        id_ff, armed_ff, we_q_ff, ce_q_ff, drive;
	logic [7:0]  busy_ff, sel_ff;
	logic [15:0] last_ff, word, val;
	initial
	begin
		for (int i = 0; i < 8; i++) mem[i] = 16'h0000;
		{id_ff, armed_ff, busy_ff, sel_ff, last_ff} = '0;
		{we_q_ff, ce_q_ff} = 2'h3;
	end
	assign ready_busy_n = (busy_ff == 8'h00);
	// Sleep on a still address keeps the word available, so it needs no state here
	assign word = id_ff ? {8'h00, ID_CODE} : (busy_ff != 8'h00) ? 16'h0008 : mem[addr[2:0]];
	assign val = byte_n ? word : {~last_ff[15:8], dq_in[15] ? word[15:8] : word[7:0]};
	// Data only after full select time, and never while reset is low or gate or select is high
	assign drive = reset_n && !ce_n && !oe_n && sel_ff == 8'h0C;
	assign dq_out = drive ? val : ~last_ff;
	always @(posedge clk)
	begin
		we_q_ff <= we_n;
		ce_q_ff <= ce_n;
		sel_ff <= ce_n ? 8'h00 : (sel_ff < 8'h0C) ? sel_ff + 8'h01 : sel_ff;
		if (drive) last_ff <= val;
		// Deselect does not stop the countdown
		if (busy_ff != 8'h00) busy_ff <= busy_ff - 8'h01;
		if (!reset_n)
			{id_ff, armed_ff} <= 2'h0;
		else if (we_n && !we_q_ff && !ce_q_ff && oe_n)
		begin
			if (armed_ff) {mem[addr[2:0]], busy_ff, armed_ff} <= {dq_in, 8'h28, 1'b0};
			else if (dq_in[7:0] == 8'hA0) armed_ff <= 1'b1;
			else if (dq_in[7:0] == 8'h90) id_ff <= 1'b1;
			else if (dq_in[7:0] == 8'hF0) id_ff <= 1'b0;
			else if (dq_in[7:0] == 8'h30) busy_ff <= 8'h78;
		end
	end
endmodule
`default_nettype wire

//--- dv/tb_flash_host_ctrl.sv
/* Self-checking bench for flash_host_ctrl with a device model.
 Assumes the checker is bound from its own file. */
`timescale 1ns/1ps
`default_nettype none
module tb_flash_host_ctrl;
	typedef struct packed {logic [1:0] op; logic [18:0] a; logic [15:0] d; logic b, w; logic [15:0] e;} row_t;
	logic        CLK, RESETN, REQ_VALID, BYTE_MODE;
	logic [1:0]  REQ_OP;
	logic [18:0] REQ_ADDR;
	logic [15:0] REQ_WDATA;
	wire         REQ_READY, RSP_VALID, BUSY, FL_CE_N, FL_OE_N, FL_WE_N, FL_RESET_N, FL_BYTE_N;
	wire         FL_READY_BUSY_N;
	wire  [15:0] RSP_RDATA, FL_DQ_O, FL_DQ_OE, dev_dq;
	wire  [17:0] FL_ADDR;
	wire  [15:0] FL_DQ_I = (FL_DQ_OE & FL_DQ_O) | (~FL_DQ_OE & dev_dq);
	int          err_count, checks_done;
	row_t        rows [10] = '{
		'{2'h1, 19'h1, 16'h00A0, 1'b0, 1'b1, 16'h0}, '{2'h1, 19'h1, 16'h1234, 1'b0, 1'b1, 16'h0},
		'{2'h0, 19'h1, 16'h0, 1'b0, 1'b0, 16'h0008}, '{2'h0, 19'h1, 16'h0, 1'b0, 1'b1, 16'h1234},
		'{2'h0, 19'h2, 16'h0, 1'b1, 1'b1, 16'h0034}, '{2'h0, 19'h3, 16'h0, 1'b1, 1'b1, 16'h0012},
		'{2'h1, 19'h0, 16'h0090, 1'b0, 1'b1, 16'h0}, '{2'h0, 19'h0, 16'h0, 1'b0, 1'b1, 16'h005A},
		'{2'h1, 19'h0, 16'h00F0, 1'b0, 1'b1, 16'h0}, '{2'h0, 19'h1, 16'h0, 1'b0, 1'b1, 16'h1234}};
	flash_host_ctrl dut (.*);
	flash_dev_model dev (.clk(CLK), .addr(FL_ADDR), .ce_n(FL_CE_N), .oe_n(FL_OE_N),
		.we_n(FL_WE_N), .reset_n(FL_RESET_N), .byte_n(FL_BYTE_N), .dq_in(FL_DQ_I),
		.dq_out(dev_dq), .ready_busy_n(FL_READY_BUSY_N));
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task tally_and_finish;
		if (err_count == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Request held until taken, then released
	task req(input logic [1:0] op, input logic [18:0] a, input logic [15:0] d, input logic b);
		@(posedge CLK);
		{REQ_VALID, REQ_OP, REQ_ADDR, REQ_WDATA, BYTE_MODE} <= {1'b1, op, a, d, b};
		do @(posedge CLK); while (REQ_READY !== 1'b1);
		REQ_VALID <= 1'b0;
	endtask
	task rd(input logic [15:0] exp);
		repeat (40) if (RSP_VALID !== 1'b1) @(posedge CLK);
		chk({15'h0, RSP_VALID}, 16'h0001);
		chk(RSP_RDATA, exp);
	endtask
	task idle;
		repeat (300) if (BUSY !== 1'b0) @(posedge CLK);
	endtask
	initial
	begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end
	initial
	begin
		#100000 err_count++;
		tally_and_finish;
	end
	initial
	begin
		{RESETN, REQ_VALID, REQ_OP, REQ_ADDR, REQ_WDATA, BYTE_MODE} = '0;
		repeat (2) @(posedge CLK);
		RESETN <= 1'b1;
		@(posedge CLK);
		#1 chk({REQ_READY, FL_CE_N, FL_RESET_N, BUSY}, 16'h000E);
		for (int i = 0; i < 10; i++)
		begin
			if (rows[i].w) idle;
			req(rows[i].op, rows[i].a, rows[i].d, rows[i].b);
			if (rows[i].op == 2'h0) rd(rows[i].e);
		end
		// Erase overlapped by a hardware reset pulse, which does not cut it short
		req(2'h1, 19'h0, 16'h0030, 1'b0);
		repeat (6) @(posedge CLK);
		req(2'h2, 19'h0, 16'h0000, 1'b0);
		@(posedge CLK);
		chk({15'h0, BUSY}, 16'h0001);
		idle;
		req(2'h0, 19'h1, 16'h0000, 1'b0);
		rd(16'h1234);
		// Unused operation code: taken, no strobe or reset pin moves, though the address is reloaded
		req(2'h3, 19'h0, 16'h0000, 1'b0);
		@(posedge CLK);
		#1 chk({REQ_READY, FL_CE_N, FL_OE_N, FL_WE_N, FL_RESET_N}, 16'h001F);
		tally_and_finish;
	end
endmodule
`default_nettype wire
